// ===== hw/ecl_pkg.sv
// Package of constants and types for the encoder counter core
// What this block does
// R1 - Default range counts zero to max, overflow wraps
// R2 - Max depth 32-bit standard, 16-bit compact
// R3 - Underflow continues at max, sets underflow
// R4 - Host writes unlock word before limit writes
// R5 - Lower limit stays below upper; reject otherwise
// R6 - Decrement at lower limit wraps, sets underflow
// R7 - Increment at upper limit wraps, sets overflow
// R8 - Underflow clears below two thirds threshold
// R9 - Overflow clears above one third threshold
// R10 - Out-of-range preset taken, flags outside limits
// R11 - Limit change leaving count outside flags it
// R12 - Encoder: A leading B counts forward
// R13 - Inversion bit flips direction in all modes
// R14 - Pulse modes: B low forward, high reverse
// R15 - Track B level readable as status
// R16 - Differential pulse mode flags open track B
// R17 - Enabled gate edge loads reset value
// R18 - Polarity bit: zero falling, one rising
// R19 - External reset raises no status flag
// R20 - Evaluation mode selects one, two, four-fold
// R21 - Modes 0,2,4 encoder; 1,3,5 pulse
// R22 - Pins synchronised before edge detection
package ecl_pkg;
	localparam logic [7:0]  ECL_ADDR_CTRL    = 8'h00;
	localparam logic [7:0]  ECL_ADDR_CODE    = 8'h04;
	localparam logic [7:0]  ECL_ADDR_LOWER   = 8'h08;
	localparam logic [7:0]  ECL_ADDR_UPPER   = 8'h0C;
	localparam logic [7:0]  ECL_ADDR_RSTVAL  = 8'h10;
	localparam logic [7:0]  ECL_ADDR_PRESET  = 8'h14;
	localparam logic [7:0]  ECL_ADDR_STATUS  = 8'h18;
	localparam logic [7:0]  ECL_ADDR_COUNT   = 8'h1C;
	localparam logic [31:0] ECL_UNLOCK_WORD  = 32'h72657375;
	localparam logic [31:0] ECL_MAX_STD      = 32'hFFFFFFFF;
	localparam logic [31:0] ECL_MAX_COMPACT  = 32'h0000FFFF;
	localparam logic [31:0] ECL_RST_LOWER    = 32'h00000000;
	localparam logic [31:0] ECL_RST_UPPER    = 32'hFFFFFFFF;
	localparam logic [31:0] ECL_RST_RSTVAL   = 32'h00000000;
	localparam logic [31:0] ECL_RST_WORD     = 32'h00000000;
	localparam logic [10:0] ECL_RST_CTRL     = 11'h000;
	localparam logic [33:0] ECL_UNF_NUM      = 34'h2;
	localparam logic [33:0] ECL_THR_DEN      = 34'h3;
	localparam logic [2:0]  ECL_MODE_DIFF_PULSE = 3'h1;
	localparam logic [1:0]  ECL_EVAL_QUAD    = 2'h0;
	localparam logic [1:0]  ECL_EVAL_DOUBLE  = 2'h1;
	localparam logic [1:0]  ECL_EVAL_SINGLE  = 2'h2;
	localparam int          ECL_SYNC_STAGES  = 3;
	localparam int          ECL_NPINS        = 4;
	localparam int          ECL_PIN_A        = 0;
	localparam int          ECL_PIN_B        = 1;
	localparam int          ECL_PIN_GATE     = 2;
	localparam int          ECL_PIN_OPEN     = 3;

	typedef struct packed {
		logic [2:0] mode;
		logic [1:0] eval;
		logic       direction_invert;
		logic       ext_rst_en;
		logic       ext_rst_pol;
		logic       b_err_disable;
		logic       compact;
		logic       user_range;
	} ecl_ctrl_t;

	typedef struct packed {
		logic track_b_error;
		logic track_b_level;
		logic count_outside_limits;
		logic overflow;
		logic underflow;
	} ecl_status_t;
endpackage

// ===== hw/ecl_counter.sv
// Encoder counter core with limits, direction, broken-wire and external reset
//
// Local design decisions: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module ecl_counter
	import ecl_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        track_a,
	input  wire logic        track_b,
	input  wire logic        gate_latch,
	input  wire logic        track_b_open,
	output logic             track_b_error,
	output logic [31:0]      count_value
);

	function automatic logic is_encoder(input logic [2:0] m);
		return (m == 3'h0) || (m == 3'h2) || (m == 3'h4);
	endfunction

	function automatic logic is_mapped(input logic [7:0] a);
		return (a == ECL_ADDR_CTRL) || (a == ECL_ADDR_CODE) || (a == ECL_ADDR_LOWER) ||
		       (a == ECL_ADDR_UPPER) || (a == ECL_ADDR_RSTVAL) || (a == ECL_ADDR_PRESET) ||
		       (a == ECL_ADDR_STATUS) || (a == ECL_ADDR_COUNT);
	endfunction

	ecl_ctrl_t             ctrl_reg;
	logic [31:0]           code_reg;
	logic [31:0]           lower_reg;
	logic [31:0]           upper_reg;
	logic [31:0]           rstval_reg;
	logic [31:0]           count_reg;
	logic [31:0]           count_next;
	logic                  unf_reg;
	logic                  ovf_reg;
	logic                  oor_reg;
	logic                  berr_reg;
	logic [31:0]           prdata_reg;
	logic                  slverr_reg;
	logic [ECL_NPINS-1:0]  pin_s1;
	logic [ECL_NPINS-1:0]  pin_s2;
	logic [ECL_NPINS-1:0]  pin_s3;
	logic [ECL_NPINS-1:0]  pin_f;
	logic [ECL_NPINS-1:0]  pin_d;
	logic [ECL_NPINS-1:0]  pin_raw;
	ecl_status_t           status;

	logic        setup;
	logic        access_wr;
	logic        unlocked;
	logic        preset_wr;
	logic [31:0] max_depth;
	logic [31:0] lo_eff;
	logic [31:0] hi_eff;
	logic [31:0] span;
	logic [31:0] thr_unf;
	logic [31:0] thr_ovf;
	logic        a_edge;
	logic        a_rise;
	logic        b_edge;
	logic        gate_rise;
	logic        gate_fall;
	logic        cnt_evt;
	logic        fwd_raw;
	logic        fwd;
	logic        ext_rst;
	logic        step_ok;
	logic        ovf_set;
	logic        unf_set;
	logic        oor_now;

	// Pin synchronisers, change accepted when stages two and three agree
	assign pin_raw = {track_b_open, gate_latch, track_b, track_a};
	genvar gi;
	generate
		for (gi = 0; gi < ECL_NPINS; gi++) begin : g_sync
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					pin_s1[gi] <= 1'b0;
					pin_s2[gi] <= 1'b0;
					pin_s3[gi] <= 1'b0;
					pin_f[gi]  <= 1'b0;
					pin_d[gi]  <= 1'b0;
				end else begin
					pin_s1[gi] <= pin_raw[gi];
					pin_s2[gi] <= pin_s1[gi];
					pin_s3[gi] <= pin_s2[gi];
					if (pin_s2[gi] == pin_s3[gi]) begin // see R22
						pin_f[gi] <= pin_s3[gi];
					end
					pin_d[gi] <= pin_f[gi];
				end
			end
		end
	endgenerate

	assign a_edge    = pin_f[ECL_PIN_A] ^ pin_d[ECL_PIN_A];
	assign a_rise    = pin_f[ECL_PIN_A] & ~pin_d[ECL_PIN_A];
	assign b_edge    = pin_f[ECL_PIN_B] ^ pin_d[ECL_PIN_B];
	assign gate_rise = pin_f[ECL_PIN_GATE] & ~pin_d[ECL_PIN_GATE];
	assign gate_fall = ~pin_f[ECL_PIN_GATE] & pin_d[ECL_PIN_GATE];

	// Edge selection per mode and evaluation
	always_comb begin
		if (is_encoder(ctrl_reg.mode)) begin // see R21
			case (ctrl_reg.eval) // see R20
				ECL_EVAL_QUAD:   cnt_evt = a_edge | b_edge;
				ECL_EVAL_DOUBLE: cnt_evt = a_edge;
				ECL_EVAL_SINGLE: cnt_evt = a_rise;
				default:         cnt_evt = a_edge | b_edge;
			endcase
			// A edge against B level, or B edge against A level
			fwd_raw = a_edge ? (pin_f[ECL_PIN_A] != pin_f[ECL_PIN_B])
			                 : (pin_f[ECL_PIN_A] == pin_f[ECL_PIN_B]); // see R12
		end else begin
			// B carries direction, so only A edges count
			cnt_evt = (ctrl_reg.eval == ECL_EVAL_SINGLE) ? a_rise : a_edge;
			fwd_raw = ~pin_f[ECL_PIN_B]; // see R14
		end
	end

	assign fwd = fwd_raw ^ ctrl_reg.direction_invert; // see R13

	// Effective range and hysteresis thresholds
	assign max_depth = ctrl_reg.compact ? ECL_MAX_COMPACT : ECL_MAX_STD; // see R2
	assign lo_eff    = ctrl_reg.user_range ? lower_reg : 32'h00000000;
	assign hi_eff    = ctrl_reg.user_range ? upper_reg : max_depth; // see R1
	assign span      = hi_eff - lo_eff;
	assign thr_unf   = lo_eff + 32'((34'(span) * ECL_UNF_NUM) / ECL_THR_DEN); // see R8
	assign thr_ovf   = lo_eff + 32'(34'(span) / ECL_THR_DEN); // see R9
	assign oor_now   = (count_reg < lo_eff) || (count_reg > hi_eff);

	// APB decode; zero wait states, read data captured in setup
	assign setup     = psel & ~penable;
	assign access_wr = psel & penable & pwrite;
	assign unlocked  = (code_reg == ECL_UNLOCK_WORD); // see R4
	assign preset_wr = access_wr && (paddr == ECL_ADDR_PRESET);
	assign pready    = 1'b1;
	assign prdata    = prdata_reg;
	assign pslverr   = psel & penable & slverr_reg;

	assign status = '{track_b_error: berr_reg, track_b_level: pin_f[ECL_PIN_B],
	                  count_outside_limits: oor_reg, overflow: ovf_reg, underflow: unf_reg};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg <= 32'h00000000;
			slverr_reg <= 1'b0;
		end else if (setup) begin
			slverr_reg <= ~is_mapped(paddr);
			case (paddr)
				ECL_ADDR_CTRL:   prdata_reg <= {21'h000000, ctrl_reg};
				ECL_ADDR_CODE:   prdata_reg <= code_reg;
				ECL_ADDR_LOWER:  prdata_reg <= lower_reg;
				ECL_ADDR_UPPER:  prdata_reg <= upper_reg;
				ECL_ADDR_RSTVAL: prdata_reg <= rstval_reg;
				ECL_ADDR_STATUS: prdata_reg <= {27'h0000000, status}; // see R15
				ECL_ADDR_COUNT:  prdata_reg <= count_reg;
				default:         prdata_reg <= 32'h00000000;
			endcase
		end
	end

	// Configuration registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg   <= ECL_RST_CTRL;
			code_reg   <= ECL_RST_WORD;
			rstval_reg <= ECL_RST_RSTVAL;
		end else if (access_wr) begin
			case (paddr)
				ECL_ADDR_CTRL:   ctrl_reg   <= pwdata[10:0];
				ECL_ADDR_CODE:   code_reg   <= pwdata;
				ECL_ADDR_RSTVAL: rstval_reg <= pwdata;
				default:         code_reg   <= code_reg;
			endcase
		end
	end

	// Limits; a write breaking the ordering is dropped silently
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lower_reg <= ECL_RST_LOWER;
			upper_reg <= ECL_RST_UPPER;
		end else if (access_wr && unlocked) begin // see R4
			if (paddr == ECL_ADDR_LOWER && pwdata < upper_reg) begin // see R5
				lower_reg <= pwdata;
			end
			if (paddr == ECL_ADDR_UPPER && pwdata > lower_reg) begin // see R5
				upper_reg <= pwdata;
			end
		end
	end

	// External reset edge and counting
	assign ext_rst = ctrl_reg.ext_rst_en &&
	                 (ctrl_reg.ext_rst_pol ? gate_rise : gate_fall); // see R17 see R18
	assign step_ok = cnt_evt && !preset_wr && !ext_rst;
	assign ovf_set = step_ok && fwd && (count_reg == hi_eff);
	assign unf_set = step_ok && !fwd && (count_reg == lo_eff);

	always_comb begin
		count_next = count_reg;
		if (preset_wr) begin
			count_next = pwdata & max_depth; // see R10
		end else if (ext_rst) begin
			count_next = rstval_reg & max_depth; // see R17
		end else if (ovf_set) begin
			count_next = lo_eff; // see R1 see R7
		end else if (unf_set) begin
			count_next = hi_eff; // see R3 see R6
		end else if (step_ok) begin
			count_next = (fwd ? count_reg + 32'h00000001 : count_reg - 32'h00000001) & max_depth;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_reg <= 32'h00000000;
		end else begin
			count_reg <= count_next;
		end
	end

	// Flags set on wrap only, so an external reset leaves them alone; set beats clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			unf_reg <= 1'b0;
			ovf_reg <= 1'b0;
		end else begin
			if (unf_set) begin
				unf_reg <= 1'b1; // see R3 see R6 see R19
			end else if (count_reg < thr_unf) begin
				unf_reg <= 1'b0; // see R8
			end
			if (ovf_set) begin
				ovf_reg <= 1'b1; // see R1 see R7 see R19
			end else if (count_reg > thr_ovf) begin
				ovf_reg <= 1'b0; // see R9
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			oor_reg  <= 1'b0;
			berr_reg <= 1'b0;
		end else begin
			oor_reg  <= oor_now; // see R10 see R11
			berr_reg <= (ctrl_reg.mode == ECL_MODE_DIFF_PULSE) && pin_f[ECL_PIN_OPEN] &&
			            !ctrl_reg.b_err_disable; // see R16
		end
	end

	assign track_b_error = berr_reg;
	assign count_value   = count_reg;

	AST_WRAP_UP: assert property (@(posedge pclk) disable iff (!presetn) // see R7
		ovf_set |=> (count_reg == $past(lo_eff)) && ovf_reg)
		else $error("increment at upper limit did not wrap with overflow");
	AST_WRAP_DN: assert property (@(posedge pclk) disable iff (!presetn) // see R6
		unf_set |=> (count_reg == $past(hi_eff)) && unf_reg)
		else $error("decrement at lower limit did not wrap with underflow");
	AST_DEFAULT_MAX: assert property (@(posedge pclk) disable iff (!presetn) // see R3
		(unf_set && !ctrl_reg.user_range && !ctrl_reg.compact) |=> count_reg == ECL_MAX_STD)
		else $error("default underflow did not continue at maximum depth");
	AST_UNF_CLEAR: assert property (@(posedge pclk) disable iff (!presetn) // see R8
		(unf_reg && !unf_set && count_reg < thr_unf) |=> !unf_reg)
		else $error("underflow flag not cleared below threshold");
	AST_OVF_CLEAR: assert property (@(posedge pclk) disable iff (!presetn) // see R9
		(ovf_reg && !ovf_set && count_reg > thr_ovf) |=> !ovf_reg)
		else $error("overflow flag not cleared above threshold");
	AST_ORDER: assert property (@(posedge pclk) disable iff (!presetn) // see R5
		lower_reg < upper_reg)
		else $error("lower limit not below upper limit");
	AST_PRESET: assert property (@(posedge pclk) disable iff (!presetn) // see R10
		(preset_wr && !ctrl_reg.compact) |=> (count_reg == $past(pwdata)) ##1 (oor_reg == $past(oor_now)))
		else $error("preset value not taken or range flag wrong");
	AST_EXT_RST: assert property (@(posedge pclk) disable iff (!presetn) // see R17
		(ext_rst && !preset_wr && !ctrl_reg.compact) |=> count_reg == $past(rstval_reg))
		else $error("external reset did not load reset value");
	AST_EXT_NOFLAG: assert property (@(posedge pclk) disable iff (!presetn) // see R19
		(ext_rst && !preset_wr) |=> !$rose(ovf_reg) && !$rose(unf_reg))
		else $error("external reset raised a status flag");
	AST_FWD_QUAD: assert property (@(posedge pclk) disable iff (!presetn) // see R12
		(step_ok && is_encoder(ctrl_reg.mode) && a_rise && !pin_f[ECL_PIN_B] &&
		 !ctrl_reg.direction_invert && !ovf_set) |=> count_reg == (($past(count_reg) + 32'h00000001) & $past(max_depth)))
		else $error("A leading B did not count forward");
	AST_PULSE_DIR: assert property (@(posedge pclk) disable iff (!presetn) // see R14
		(step_ok && !is_encoder(ctrl_reg.mode)) |-> fwd == (!pin_f[ECL_PIN_B] ^ ctrl_reg.direction_invert))
		else $error("pulse mode direction does not follow track B");
	AST_BERR: assert property (@(posedge pclk) disable iff (!presetn) // see R16
		ctrl_reg.b_err_disable |=> !track_b_error)
		else $error("broken-wire indication not disabled");
	AST_LOWER_KEEP: assert property (@(posedge pclk) disable iff (!presetn) // see R5
		(access_wr && paddr == ECL_ADDR_LOWER && pwdata >= upper_reg) |=> $stable(lower_reg))
		else $error("lower limit write breaking the order was taken");
	AST_UPPER_KEEP: assert property (@(posedge pclk) disable iff (!presetn) // see R5
		(access_wr && paddr == ECL_ADDR_UPPER && pwdata <= lower_reg) |=> $stable(upper_reg))
		else $error("upper limit write breaking the order was taken");
	AST_LOCKED: assert property (@(posedge pclk) disable iff (!presetn) // see R4
		(access_wr && !unlocked && paddr == ECL_ADDR_LOWER) |=> $stable(lower_reg))
		else $error("lower limit changed while locked");
	AST_OOR: assert property (@(posedge pclk) disable iff (!presetn) // see R11
		oor_now |=> oor_reg)
		else $error("count outside limits not flagged");

	COV_OVF: cover property (@(posedge pclk) disable iff (!presetn) ovf_set);
	COV_UNF: cover property (@(posedge pclk) disable iff (!presetn) unf_set);
	COV_EXT: cover property (@(posedge pclk) disable iff (!presetn) ext_rst ##1 cnt_evt);
	COV_OOR: cover property (@(posedge pclk) disable iff (!presetn) preset_wr ##2 oor_reg);

endmodule
`default_nettype wire

// ===== test/ecl_encoder_model.sv
// Behavioural encoder and pulse generator driving the counter pins
`timescale 1ns/1ps
`default_nettype none
module ecl_encoder_model (
	input  wire logic pclk,
	output logic      track_a,
	output logic      track_b,
	output logic      gate_latch,
	output logic      track_b_open
);
	logic [1:0] phase = 2'h0;
	initial begin
		track_a = 1'b0;
		track_b = 1'b0;
		gate_latch = 1'b0;
		track_b_open = 1'b0;
	end
	// Long hold, so each level outlives the pin filter
	task automatic settle();
		repeat (8) @(posedge pclk);
	endtask
	// Gray order 00,10,11,01: forward keeps A a quarter period ahead
	task automatic quad_step(input logic fwd);
		phase = fwd ? phase + 2'h1 : phase - 2'h1;
		@(posedge pclk);
		track_a <= ^phase;
		track_b <= phase[1];
		settle();
	endtask
	task automatic pulse();
		@(posedge pclk);
		track_a <= 1'b1;
		settle();
		@(posedge pclk);
		track_a <= 1'b0;
		settle();
	endtask
	task automatic rest();
		phase = 2'h0;
		@(posedge pclk);
		track_a <= 1'b0;
		track_b <= 1'b0;
		settle();
	endtask
	task automatic set_b(input logic v);
		@(posedge pclk);
		track_b <= v;
		settle();
	endtask
	// An open line reads low, as the wire has nothing driving it
	task automatic set_open(input logic v);
		@(posedge pclk);
		track_b_open <= v;
		track_b <= 1'b0;
		settle();
	endtask
	task automatic set_gate(input logic v);
		@(posedge pclk);
		gate_latch <= v;
		settle();
	endtask
endmodule
`default_nettype wire

// ===== test/testbench.sv
// Self-checking bench for the encoder counter core
`timescale 1ns/1ps
`default_nettype none
`define CHK(name, exp, got) \
	begin total_checks++; if ((got) !== (exp)) begin miscompares++; \
	$display("CHECK FAILED %s expected %h seen %h", name, exp, got); end end
module testbench
	import ecl_pkg::*;
;
	localparam logic [31:0] ALL_BITS = 32'hFFFFFFFF;
	logic        pclk = 1'b0;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        track_a;
	logic        track_b;
	logic        gate_latch;
	logic        track_b_open;
	logic        track_b_error;
	logic [31:0] count_value;
	int          miscompares = 0;
	int          total_checks = 0;
	always #2.5 pclk = ~pclk;
	ecl_counter ecl_counter_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .track_a(track_a), .track_b(track_b), .gate_latch(gate_latch),
		.track_b_open(track_b_open), .track_b_error(track_b_error), .count_value(count_value));
	ecl_encoder_model ecl_encoder_model_inst (.pclk(pclk), .track_a(track_a), .track_b(track_b),
		.gate_latch(gate_latch), .track_b_open(track_b_open));
	task automatic results();
		if (miscompares == 0 && total_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// Request held until pready is seen high at a rising edge
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic        e;
		apb(a, 1'b1, d, q, e);
	endtask
	// Flags trail the count by a cycle, so let them land first
	task automatic chk_reg(input string name, input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
		logic [31:0] q;
		logic        e;
		repeat (3) @(posedge pclk);
		apb(a, 1'b0, 32'h0, q, e);
		`CHK(name, x, q & m)
	endtask
	task automatic preset(input logic [31:0] v);
		wr(ECL_ADDR_PRESET, v);
		repeat (3) @(posedge pclk);
	endtask
	task automatic t_reset();
		logic [31:0] q;
		logic        e;
		chk_reg("ctrl", ECL_ADDR_CTRL, ALL_BITS, 32'h0);
		chk_reg("upper", ECL_ADDR_UPPER, ALL_BITS, ECL_MAX_STD);
		chk_reg("count", ECL_ADDR_COUNT, ALL_BITS, 32'h0);
		chk_reg("rstval", ECL_ADDR_RSTVAL, ALL_BITS, ECL_RST_RSTVAL);
		apb(8'h20, 1'b0, 32'h0, q, e);
		`CHK("unmapped", 1'b1, e)
	endtask
	task automatic t_wrap();
		for (int d = 0; d < 2; d++) begin
			ecl_encoder_model_inst.quad_step(d[0]);
			chk_reg("count", ECL_ADDR_COUNT, ALL_BITS, d[0] ? 32'h0 : ECL_MAX_STD);
			chk_reg("wrap flag", ECL_ADDR_STATUS, 32'h3, d[0] ? 32'h2 : 32'h1);
		end
		wr(ECL_ADDR_CTRL, 32'h2);
		ecl_encoder_model_inst.quad_step(1'b0);
		chk_reg("compact", ECL_ADDR_COUNT, ALL_BITS, ECL_MAX_COMPACT);
	endtask
	task automatic t_limits();
		wr(ECL_ADDR_LOWER, 32'h190);
		chk_reg("locked", ECL_ADDR_LOWER, ALL_BITS, 32'h0);
		wr(ECL_ADDR_CODE, ECL_UNLOCK_WORD);
		wr(ECL_ADDR_LOWER, 32'h190);
		wr(ECL_ADDR_UPPER, 32'hFFF);
		wr(ECL_ADDR_LOWER, 32'hFFF);
		wr(ECL_ADDR_UPPER, 32'h190);
		chk_reg("lower", ECL_ADDR_LOWER, ALL_BITS, 32'h190);
		chk_reg("upper", ECL_ADDR_UPPER, ALL_BITS, 32'hFFF);
		wr(ECL_ADDR_CTRL, 32'h1);
		preset(32'h190);
		ecl_encoder_model_inst.quad_step(1'b0);
		chk_reg("count", ECL_ADDR_COUNT, ALL_BITS, 32'hFFF);
		chk_reg("underflow", ECL_ADDR_STATUS, 32'h7, 32'h1);
		preset(32'hB2F);
		chk_reg("underflow", ECL_ADDR_STATUS, 32'h7, 32'h1);
		preset(32'hB2E);
		chk_reg("underflow", ECL_ADDR_STATUS, 32'h7, 32'h0);
		preset(32'hFFF);
		ecl_encoder_model_inst.quad_step(1'b1);
		chk_reg("count", ECL_ADDR_COUNT, ALL_BITS, 32'h190);
		chk_reg("overflow", ECL_ADDR_STATUS, 32'h7, 32'h2);
		preset(32'h65F);
		chk_reg("overflow", ECL_ADDR_STATUS, 32'h7, 32'h2);
		preset(32'h660);
		chk_reg("overflow", ECL_ADDR_STATUS, 32'h7, 32'h0);
		preset(32'h1388);
		chk_reg("count", ECL_ADDR_COUNT, ALL_BITS, 32'h1388);
		chk_reg("outside", ECL_ADDR_STATUS, 32'h7, 32'h4);
		preset(32'h3E8);
		chk_reg("inside", ECL_ADDR_STATUS, 32'h4, 32'h0);
		wr(ECL_ADDR_UPPER, 32'h384);
		chk_reg("outside", ECL_ADDR_STATUS, 32'h7, 32'h4);
	endtask
	task automatic t_direction();
		logic [31:0] x;
		int          n;
		for (int ev = 0; ev < 4; ev++) begin
			for (int k = 0; k < 4; k++) begin
				wr(ECL_ADDR_CTRL, 32'(ev << 6) | 32'(k[0]) << 5);
				preset(32'h64);
				repeat (4) ecl_encoder_model_inst.quad_step(k[1]);
				n = (ev == 3) ? 4 : (4 >> ev);
				x = (k[0] ^ k[1]) ? 32'h64 + 32'(n) : 32'h64 - 32'(n);
				chk_reg("direction", ECL_ADDR_COUNT, ALL_BITS, x);
				`CHK("count pin", x, count_value)
			end
		end
	endtask
	task automatic t_pulse();
		logic [31:0] x;
		ecl_encoder_model_inst.rest();
		for (int m = 1; m < 6; m += 2) begin
			for (int k = 0; k < 8; k++) begin
				wr(ECL_ADDR_CTRL, 32'(m << 8) | (k[2] ? 32'h40 : 32'h80) | 32'(k[0]) << 5);
				ecl_encoder_model_inst.set_b(k[1]);
				preset(32'h64);
				repeat (2) ecl_encoder_model_inst.pulse();
				x = (k[0] ^ k[1]) ? (k[2] ? 32'h60 : 32'h62) : (k[2] ? 32'h68 : 32'h66);
				chk_reg("pulse", ECL_ADDR_COUNT, ALL_BITS, x);
				chk_reg("b level", ECL_ADDR_STATUS, 32'h8, 32'(k[1]) << 3);
			end
		end
	endtask
	task automatic t_wire();
		wr(ECL_ADDR_CTRL, 32'h100);
		ecl_encoder_model_inst.set_open(1'b1);
		`CHK("wire", 1'b1, track_b_error)
		chk_reg("wire", ECL_ADDR_STATUS, 32'h10, 32'h10);
		wr(ECL_ADDR_CTRL, 32'h104);
		repeat (4) @(posedge pclk);
		`CHK("wire off", 1'b0, track_b_error)
		wr(ECL_ADDR_CTRL, 32'h300);
		repeat (4) @(posedge pclk);
		`CHK("wire ttl", 1'b0, track_b_error)
		ecl_encoder_model_inst.set_open(1'b0);
	endtask
	// Gate toggles each pass, so every active edge repeats without re-arming
	task automatic t_ext_reset();
		logic [31:0] s0;
		logic [31:0] s1;
		logic        e;
		logic        lv;
		lv = 1'b0;
		wr(ECL_ADDR_RSTVAL, 32'h7);
		for (int pol = 0; pol < 2; pol++) begin
			wr(ECL_ADDR_CTRL, 32'h10 | 32'(pol) << 3);
			for (int t = 0; t < 4; t++) begin
				lv = ~lv;
				preset(32'h32);
				apb(ECL_ADDR_STATUS, 1'b0, 32'h0, s0, e);
				ecl_encoder_model_inst.set_gate(lv);
				chk_reg("gate edge", ECL_ADDR_COUNT, ALL_BITS, (lv == pol[0]) ? 32'h7 : 32'h32);
				apb(ECL_ADDR_STATUS, 1'b0, 32'h0, s1, e);
				`CHK("quiet", s0 & 32'h7, s1 & 32'h7)
			end
		end
	endtask
	task automatic t_mid_reset();
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		wr(ECL_ADDR_LOWER, 32'h10);
		chk_reg("relocked", ECL_ADDR_LOWER, ALL_BITS, ECL_RST_LOWER);
		t_reset();
	endtask
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_wrap();
		t_limits();
		t_direction();
		t_pulse();
		t_wire();
		t_ext_reset();
		t_mid_reset();
		results();
	end
	// Whole run is a few thousand cycles; this span is far beyond it
	initial begin
		#150000;
		miscompares++;
		results();
	end
endmodule
`default_nettype wire
